/* File: rtl/alc_pkg.sv */
// constants, widths and shared decode functions for adaptive current control
package alc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int LEVEL_W = 9;   // current level, 0..511 steps
   localparam int BASE_W  = 5;   // learn base level field
   localparam int LOSS_W  = 11;  // loss parameter and power samples
   localparam int CNT_W   = 12;  // load power count, one bit of headroom

   ////////////////////////////////////////////////////////////////////////////
   // learning level arithmetic
   localparam int BASE_MULT_SHIFT = 3;           // first level = base * 8
   localparam logic [1:0] INC_128 = 2'h0;
   localparam logic [1:0] INC_16  = 2'h1;
   localparam logic [1:0] INC_32  = 2'h2;
   localparam logic [1:0] INC_64  = 2'h3;
   localparam logic [2:0] SHIFT_128 = 3'h7;
   localparam logic [2:0] SHIFT_16  = 3'h4;
   localparam logic [2:0] SHIFT_32  = 3'h5;
   localparam logic [2:0] SHIFT_64  = 3'h6;
   localparam logic [5:0] DWELL_UNIT = 6'h08;    // half-cycles per code step

   ////////////////////////////////////////////////////////////////////////////
   // power filter and current reduction pacing
   localparam int FILT_SHIFT = 4;
   localparam int LOWER_PERIOD_CYCLES = 1000;    // one step down per period

   ////////////////////////////////////////////////////////////////////////////
   // quiet decay loop timing and dividers
   localparam int CLK_PERIOD_NS  = 50;
   localparam int ZC_DEFAULT_NS  = 2000;
   localparam int ZC_MAX_NS      = 5000;
   localparam int ZC_STEP_NS     = 1000;
   localparam int ZC_DEFAULT_CYC = ZC_DEFAULT_NS / CLK_PERIOD_NS;
   localparam int ZC_MAX_CYC     = ZC_MAX_NS / CLK_PERIOD_NS;
   localparam int ZC_STEP_CYC    = ZC_STEP_NS / CLK_PERIOD_NS;
   localparam logic [2:0] DIV_CODE_256 = 3'h3;   // code 011 is 1/256
   localparam logic [3:0] DIV_BASE_SHIFT = 4'h5; // code 0 is 1/32

   ////////////////////////////////////////////////////////////////////////////
   // increment field to step count
   function automatic logic [LEVEL_W-1:0] inc_steps(input logic [1:0] code);
      case (code)
         INC_16:  inc_steps = 9'h010;
         INC_32:  inc_steps = 9'h020;
         INC_64:  inc_steps = 9'h040;
         default: inc_steps = 9'h080;
      endcase
   endfunction : inc_steps

   // increment field to log2 of step count
   function automatic logic [2:0] inc_shift(input logic [1:0] code);
      case (code)
         INC_16:  inc_shift = SHIFT_16;
         INC_32:  inc_shift = SHIFT_32;
         INC_64:  inc_shift = SHIFT_64;
         default: inc_shift = SHIFT_128;
      endcase
   endfunction : inc_shift

   // gain divider code to right shift, 011 gives 8 (1/256)
   function automatic logic [3:0] div_shift(input logic [2:0] code);
      div_shift = DIV_BASE_SHIFT + {1'b0, code};
   endfunction : div_shift

endpackage : alc_pkg

/* File: rtl/alc_interp_if.sv */
// interface between the controller and the loss interpolator
`timescale 1ns/1ps
interface alc_interp_if;
   logic [alc_pkg::LEVEL_W-1:0] level_low;
   logic [2:0]                  span_shift;
   logic [alc_pkg::LOSS_W-1:0]  loss_low;
   logic [alc_pkg::LOSS_W-1:0]  loss_high;
   logic [alc_pkg::LEVEL_W-1:0] level_now;
   logic [alc_pkg::LOSS_W-1:0]  loss_now;

   modport ctrl   (output level_low, span_shift, loss_low, loss_high,
                   level_now, input loss_now);
   modport interp (input level_low, span_shift, loss_low, loss_high,
                   level_now, output loss_now);
endinterface : alc_interp_if

/* File: rtl/alc_interp.sv */
// linear interpolation of the loss parameter between two learned points
`timescale 1ns/1ps
module alc_interp
(
   // operands and result
   alc_interp_if.interp bus
);
   logic signed [12:0] slope;
   logic signed [10:0] offs;
   logic signed [24:0] prod;
   logic signed [24:0] scaled;
   logic signed [24:0] sum;

   // span is a power of two, so the divide is a shift
   always_comb
   begin
      slope  = $signed({2'b00, bus.loss_high}) - $signed({2'b00, bus.loss_low});
      offs   = $signed({2'b00, bus.level_now}) - $signed({2'b00, bus.level_low});
      prod   = 25'(slope * offs);
      scaled = prod >>> bus.span_shift;
      sum    = scaled + $signed({14'h0000, bus.loss_low});
      // extrapolation may leave the range, clamp rather than wrap
      if (sum < 0)
         bus.loss_now = '0;
      else if (sum > 25'sh7ff)
         bus.loss_now = '1;
      else
         bus.loss_now = sum[alc_pkg::LOSS_W-1:0];
   end
endmodule : alc_interp

/* File: rtl/alc_top.sv */
// load adaptive coil current control with no-load loss learning
`timescale 1ns/1ps
module alc_top
#(
   parameter int LOWER_PERIOD = alc_pkg::LOWER_PERIOD_CYCLES
)
(
   // clock and reset
   input  wire logic                        core_clk,
   input  wire logic                        rst,
   // configuration
   input  wire logic                        adaptive_current_enable,
   input  wire logic                        learning_launch_wr,
   input  wire logic [alc_pkg::BASE_W-1:0]  learn_base_level,
   input  wire logic [1:0]                  learn_level_increment,
   input  wire logic [1:0]                  learn_dwell_select,
   input  wire logic [alc_pkg::LEVEL_W-1:0] full_scale_level,
   input  wire logic [alc_pkg::CNT_W-1:0]   load_high_thresh,
   input  wire logic [alc_pkg::CNT_W-1:0]   load_low_thresh,
   // quiet decay loop settings
   input  wire logic [1:0]                  zero_cross_sample_time,
   input  wire logic [2:0]                  prop_gain_divider,
   input  wire logic [2:0]                  integ_gain_divider,
   // supply power monitor and indexer
   input  wire logic [alc_pkg::LOSS_W-1:0]  supply_power,
   input  wire logic                        supply_power_valid,
   input  wire logic                        half_cycle_tick,
   // status
   output logic                             learning_launch,
   output logic                             learning_complete,
   output logic [alc_pkg::LOSS_W-1:0]       learned_loss_low,
   output logic [alc_pkg::LOSS_W-1:0]       learned_loss_high,
   output logic [alc_pkg::LOSS_W-1:0]       constant_loss_param,
   output logic [alc_pkg::CNT_W-1:0]        load_power_count,
   // current command and loop timing
   output logic [alc_pkg::LEVEL_W-1:0]      coil_current_level,
   output logic [6:0]                       zc_sample_cycles,
   output logic [3:0]                       prop_div_shift,
   output logic [3:0]                       integ_div_shift
);

   typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} alc_state_e;

   ////////////////////////////////////////////////////////////////////////////
   // learning level derivation
   logic [alc_pkg::LEVEL_W-1:0] level1;
   logic [alc_pkg::LEVEL_W-1:0] level2;
   logic [5:0]                  dwell_target;

   // both levels are fixed by the fields, so decode them combinationally
   always_comb
   begin
      level1 = {{(alc_pkg::LEVEL_W-alc_pkg::BASE_W-3){1'b0}},
                learn_base_level, 3'b000};
      level2 = level1 + alc_pkg::inc_steps(learn_level_increment);
      dwell_target = 6'({4'h0, learn_dwell_select} + 6'h01)
                     * alc_pkg::DWELL_UNIT;
   end

   ////////////////////////////////////////////////////////////////////////////
   // supply power filter
   logic [alc_pkg::LOSS_W-1:0] filt_r;
   logic [alc_pkg::LOSS_W-1:0] filt_nxt;
   logic signed [11:0]         filt_diff;

   // first order low pass, smooths ripple over the electrical cycle
   always_comb
   begin
      filt_diff = $signed({1'b0, supply_power}) - $signed({1'b0, filt_r});
      filt_nxt  = filt_r;
      if (supply_power_valid)
         filt_nxt = 11'(filt_r + 11'(filt_diff >>> alc_pkg::FILT_SHIFT));
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         filt_r <= '0;
      else
         filt_r <= filt_nxt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // learning sequencer
   alc_state_e                 state_r;
   alc_state_e                 state_nxt;
   logic [5:0]                 dwell_r;
   logic [5:0]                 dwell_nxt;
   logic                       launch_r;
   logic                       launch_nxt;
   logic                       done_r;
   logic                       done_nxt;
   logic [alc_pkg::LOSS_W-1:0] low_r;
   logic [alc_pkg::LOSS_W-1:0] low_nxt;
   logic [alc_pkg::LOSS_W-1:0] high_r;
   logic [alc_pkg::LOSS_W-1:0] high_nxt;
   logic                       dwell_end;

   // the filter value at the end of each dwell is the unloaded loss
   always_comb
   begin
      state_nxt  = state_r;
      dwell_nxt  = dwell_r;
      launch_nxt = launch_r;
      done_nxt   = done_r;
      low_nxt    = low_r;
      high_nxt   = high_r;
      dwell_end  = half_cycle_tick && (dwell_r + 6'h01 >= dwell_target);
      case (state_r)
         ST_IDLE:
         begin
            // launch only honoured while adaptation is enabled
            if (learning_launch_wr && adaptive_current_enable)
            begin
               state_nxt  = ST_LOW;
               dwell_nxt  = '0;
               launch_nxt = 1'b1;
               done_nxt   = 1'b0;
            end
         end
         ST_LOW:
         begin
            if (half_cycle_tick)
               dwell_nxt = dwell_r + 6'h01;
            if (dwell_end)
            begin
               low_nxt   = filt_r;
               dwell_nxt = '0;
               state_nxt = ST_HIGH;
            end
         end
         ST_HIGH:
         begin
            if (half_cycle_tick)
               dwell_nxt = dwell_r + 6'h01;
            if (dwell_end)
            begin
               high_nxt   = filt_r;
               dwell_nxt  = '0;
               launch_nxt = 1'b0;
               done_nxt   = 1'b1;
               state_nxt  = ST_IDLE;
            end
         end
         default:
         begin
            state_nxt  = ST_IDLE;
            launch_nxt = 1'b0;
         end
      endcase
      // disabling mid-run abandons the run, stored results stay as they were
      if (!adaptive_current_enable && state_r != ST_IDLE)
      begin
         state_nxt  = ST_IDLE;
         launch_nxt = 1'b0;
         low_nxt    = low_r;
         high_nxt   = high_r;
         done_nxt   = done_r;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r  <= ST_IDLE;
         dwell_r  <= '0;
         launch_r <= 1'b0;
         done_r   <= 1'b0;
         low_r    <= '0;
         high_r   <= '0;
      end
      else
      begin
         state_r  <= state_nxt;
         dwell_r  <= dwell_nxt;
         launch_r <= launch_nxt;
         done_r   <= done_nxt;
         low_r    <= low_nxt;
         high_r   <= high_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // loss interpolation at the present current
   alc_interp_if ip ();
   logic [alc_pkg::LEVEL_W-1:0] cur_r;
   logic [alc_pkg::LEVEL_W-1:0] cur_nxt;

   assign ip.level_low  = level1;
   assign ip.span_shift = alc_pkg::inc_shift(learn_level_increment);
   assign ip.loss_low   = low_r;
   assign ip.loss_high  = high_r;
   assign ip.level_now  = cur_r;

   alc_interp u_interp
   (
      .bus (ip.interp)
   );

   ////////////////////////////////////////////////////////////////////////////
   // load estimate and current adaptation
   logic [alc_pkg::LOSS_W-1:0] loss_r;
   logic [alc_pkg::LOSS_W-1:0] loss_nxt;
   logic [alc_pkg::CNT_W-1:0]  load_r;
   logic [alc_pkg::CNT_W-1:0]  load_nxt;
   logic [15:0]                pace_r;
   logic [15:0]                pace_nxt;
   logic                       adapting;

   // loss is taken at the present current only, load never feeds it
   always_comb
   begin
      adapting = adaptive_current_enable && state_r == ST_IDLE;
      loss_nxt = ip.loss_now;
      // load part is what the supply gives beyond the constant loss
      if (filt_r > ip.loss_now)
         load_nxt = {1'b0, filt_r - ip.loss_now};
      else
         load_nxt = '0;
      cur_nxt  = cur_r;
      pace_nxt = pace_r;
      if (state_r == ST_LOW)
         cur_nxt = level1;
      else if (state_r == ST_HIGH)
         cur_nxt = level2;
      else if (!adapting)
      begin
         cur_nxt  = full_scale_level;
         pace_nxt = '0;
      end
      else if (load_r >= load_high_thresh)
      begin
         // step loss costs more than heat, so restore full current at once
         cur_nxt  = full_scale_level;
         pace_nxt = '0;
      end
      else if (load_r < load_low_thresh && cur_r > level1)
      begin
         // slow descent keeps the loss estimate settled between steps
         if (pace_r >= 16'(LOWER_PERIOD - 1))
         begin
            cur_nxt  = cur_r - 9'h001;
            pace_nxt = '0;
         end
         else
            pace_nxt = pace_r + 16'h0001;
      end
      else
         pace_nxt = '0;
      if (state_r == ST_IDLE && cur_nxt > full_scale_level)
         cur_nxt = full_scale_level;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cur_r  <= '0;
         pace_r <= '0;
         loss_r <= '0;
         load_r <= '0;
      end
      else
      begin
         cur_r  <= cur_nxt;
         pace_r <= pace_nxt;
         loss_r <= loss_nxt;
         load_r <= load_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // quiet decay loop timing and divider decode
   logic [6:0] zc_r;
   logic [6:0] zc_nxt;
   logic [3:0] pdiv_r;
   logic [3:0] pdiv_nxt;
   logic [3:0] idiv_r;
   logic [3:0] idiv_nxt;

   // code 0 is the 2 us default, each code adds 1 us, clamped at 5 us
   always_comb
   begin
      zc_nxt = 7'(alc_pkg::ZC_DEFAULT_CYC
                  + int'(zero_cross_sample_time) * alc_pkg::ZC_STEP_CYC);
      if (zc_nxt > 7'(alc_pkg::ZC_MAX_CYC))
         zc_nxt = 7'(alc_pkg::ZC_MAX_CYC);
      pdiv_nxt = alc_pkg::div_shift(prop_gain_divider);
      idiv_nxt = alc_pkg::div_shift(integ_gain_divider);
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         zc_r   <= 7'(alc_pkg::ZC_DEFAULT_CYC);
         pdiv_r <= alc_pkg::div_shift(alc_pkg::DIV_CODE_256);
         idiv_r <= alc_pkg::div_shift(alc_pkg::DIV_CODE_256);
      end
      else
      begin
         zc_r   <= zc_nxt;
         pdiv_r <= pdiv_nxt;
         idiv_r <= idiv_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs, all straight from flip-flops
   assign learning_launch     = launch_r;
   assign learning_complete   = done_r;
   assign learned_loss_low    = low_r;
   assign learned_loss_high   = high_r;
   assign constant_loss_param = loss_r;
   assign load_power_count    = load_r;
   assign coil_current_level  = cur_r;
   assign zc_sample_cycles    = zc_r;
   assign prop_div_shift      = pdiv_r;
   assign integ_div_shift     = idiv_r;

endmodule : alc_top

/* File: tb/alc_chk.sv */
// port assertions for adaptive current control
`timescale 1ns/1ps
module alc_chk
#(
   parameter int LOWER_PERIOD = 4
)
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // configuration
   input wire logic        adaptive_current_enable,
   input wire logic        learning_launch_wr,
   input wire logic [4:0]  learn_base_level,
   input wire logic [1:0]  learn_level_increment,
   input wire logic [8:0]  full_scale_level,
   input wire logic [11:0] load_high_thresh,
   input wire logic [1:0]  zero_cross_sample_time,
   input wire logic [2:0]  prop_gain_divider,
   input wire logic [2:0]  integ_gain_divider,
   // status and command
   input wire logic        learning_launch,
   input wire logic        learning_complete,
   input wire logic [11:0] load_power_count,
   input wire logic [8:0]  coil_current_level,
   input wire logic [6:0]  zc_sample_cycles,
   input wire logic [3:0]  prop_div_shift,
   input wire logic [3:0]  integ_div_shift
);
   logic [8:0] lvl1;
   logic [8:0] step;

   // learn levels decoded here, apart from the design
   assign lvl1 = {1'b0, learn_base_level, 3'h0};
   assign step = (learn_level_increment == 2'h0) ? 9'h080 :
                 9'h008 << learn_level_increment;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   ////////////////////////////////////////////////////////////////////////
   // learning steps: start, then one hop to the second level
   sequence s_start;
      $rose(learning_launch);
   endsequence
   sequence s_hop;
      learning_launch && $past(learning_launch, 2) &&
         $changed(coil_current_level);
   endsequence

   a_launch_ack : assert property (
      learning_launch_wr && adaptive_current_enable && !learning_launch
      |=> learning_launch && !learning_complete)
      else $error("launch not acknowledged");
   a_launch_refuse : assert property (
      learning_launch_wr && !adaptive_current_enable && !learning_launch
      |=> !learning_launch)
      else $error("launch taken while disabled");
   a_first_level : assert property (
      s_start |=> coil_current_level == lvl1)
      else $error("first learn level wrong");
   a_second_level : assert property (
      s_hop |-> coil_current_level == lvl1 + step)
      else $error("second learn level wrong");
   a_done_flag : assert property (
      $fell(learning_launch) && adaptive_current_enable
      |-> learning_complete)
      else $error("complete flag missing at end");
   a_full_jump : assert property (
      adaptive_current_enable && !learning_launch && !learning_launch_wr &&
      load_power_count >= load_high_thresh
      |=> coil_current_level == full_scale_level)
      else $error("current not raised at once");
   a_slow_lower : assert property (
      adaptive_current_enable && !learning_launch && !$past(learning_launch)
      && $past(coil_current_level) <= full_scale_level &&
      coil_current_level < $past(coil_current_level)
      |-> coil_current_level == $past(coil_current_level) - 9'h001)
      else $error("current lowered by more than one");
   a_off_full : assert property (
      (!adaptive_current_enable && !learning_launch) [*2]
      |-> coil_current_level == full_scale_level)
      else $error("current adapted while disabled");
   a_zc_follow : assert property (
      1'b1 |=> zc_sample_cycles ==
         7'h28 + 7'h14 * {5'h00, $past(zero_cross_sample_time)})
      else $error("sample time wrong");
   a_div_follow : assert property (
      1'b1 |=> prop_div_shift == 4'h5 + $past(prop_gain_divider) &&
         integ_div_shift == 4'h5 + $past(integ_gain_divider))
      else $error("divider shift wrong");
endmodule : alc_chk

bind alc_top alc_chk #(.LOWER_PERIOD(LOWER_PERIOD)) u_chk
(
   .core_clk, .rst, .adaptive_current_enable, .learning_launch_wr,
   .learn_base_level, .learn_level_increment, .full_scale_level,
   .load_high_thresh, .zero_cross_sample_time, .prop_gain_divider,
   .integ_gain_divider, .learning_launch, .learning_complete,
   .load_power_count, .coil_current_level, .zc_sample_cycles,
   .prop_div_shift, .integ_div_shift
);

/* File: tb/alc_motor.sv */
// motor and supply monitor model with half-cycle source
`timescale 1ns/1ps
module alc_motor
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst,
   // current command and bench controls
   input wire logic [8:0]  coil_level,
   input wire logic [9:0]  load,
   input wire logic [4:0]  tick_gap,
   input wire logic        slow,
   // power samples and ticks
   output logic [10:0]     supply_power,
   output logic            supply_power_valid,
   output logic            half_cycle_tick
);
   logic [4:0]  gap_r;
   logic        alt_r;
   logic [10:0] pwr;

   // loss linear in current, load power added on top
   assign pwr = {1'b0, coil_level, 1'b0} + {1'b0, load};
   // slow mode samples every other cycle; stale data is inverted
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
      begin
         gap_r <= 5'h00;
         alt_r <= 1'b0;
         supply_power <= 11'h000;
         supply_power_valid <= 1'b0;
         half_cycle_tick <= 1'b0;
      end
      else
      begin
         alt_r <= ~alt_r;
         supply_power_valid <= ~slow | alt_r;
         supply_power <= (~slow | alt_r) ? pwr : ~pwr;
         half_cycle_tick <= (gap_r == 5'h00);
         gap_r <= (gap_r == 5'h00) ? tick_gap : gap_r - 5'h01;
      end
endmodule : alc_motor

/* File: tb/tb.sv */
// self-checking bench for adaptive current control
`timescale 1ns/1ps
module tb;
   typedef struct {string nm; int sel; logic [11:0] lo; logic [11:0] hi;}
      alc_note_s;
   logic        core_clk, rst, adaptive_current_enable, learning_launch_wr;
   logic        supply_power_valid, half_cycle_tick, slow;
   logic        learning_launch, learning_complete;
   logic [1:0]  learn_level_increment, learn_dwell_select;
   logic [1:0]  zero_cross_sample_time;
   logic [2:0]  prop_gain_divider, integ_gain_divider;
   logic [3:0]  prop_div_shift, integ_div_shift;
   logic [4:0]  learn_base_level, tick_gap;
   logic [6:0]  zc_sample_cycles;
   logic [8:0]  full_scale_level, coil_current_level;
   logic [9:0]  load;
   logic [10:0] supply_power, learned_loss_low, learned_loss_high;
   logic [10:0] constant_loss_param;
   logic [11:0] load_high_thresh, load_low_thresh, load_power_count, v;
   int          err_total = 0;
   int          checked = 0;
   int          ticks = 0;
   int          lvl2;
   alc_note_s   n;
   alc_note_s   notes[$];
   event        look;

   alc_top #(.LOWER_PERIOD(4)) DUT
   (
      .core_clk, .rst, .adaptive_current_enable, .learning_launch_wr,
      .learn_base_level, .learn_level_increment, .learn_dwell_select,
      .full_scale_level, .load_high_thresh, .load_low_thresh,
      .zero_cross_sample_time, .prop_gain_divider, .integ_gain_divider,
      .supply_power, .supply_power_valid, .half_cycle_tick,
      .learning_launch, .learning_complete, .learned_loss_low,
      .learned_loss_high, .constant_loss_param, .load_power_count,
      .coil_current_level, .zc_sample_cycles, .prop_div_shift,
      .integ_div_shift
   );
   alc_motor u_motor
   (
      .core_clk, .rst, .coil_level(coil_current_level), .load, .tick_gap,
      .slow, .supply_power, .supply_power_valid, .half_cycle_tick
   );

   ////////////////////////////////////////////////////////////////////////
   // clock, tick count at the first learn level, hang guard
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(posedge core_clk)
      if (learning_launch === 1'b1 && half_cycle_tick === 1'b1 &&
          coil_current_level === 9'h0c0)
         ticks <= ticks + 1;
   initial
   begin
      repeat (30000) @(posedge core_clk);
      err_total++;
      finish_test();
   end

   task automatic check(input string nm, input logic [11:0] seen,
                        input logic [11:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic finish_test();
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : finish_test

   function automatic logic [11:0] probe(input int sel);
      case (sel)
         0: probe = {3'h0, coil_current_level};
         1: probe = {11'h000, learning_launch};
         2: probe = {11'h000, learning_complete};
         3: probe = {1'b0, learned_loss_low};
         4: probe = {1'b0, learned_loss_high};
         5: probe = {1'b0, constant_loss_param};
         6: probe = load_power_count;
         7: probe = {5'h00, zc_sample_cycles};
         8: probe = {8'h00, prop_div_shift};
         9: probe = {8'h00, integ_div_shift};
         default: probe = ticks[11:0];
      endcase
   endfunction : probe

   // expected range is queued, then the monitor is woken
   task automatic note(input string nm, input int sel, input int lo,
                       input int hi);
      notes.push_back('{nm, sel, lo[11:0], hi[11:0]});
      -> look;
      #1;
   endtask : note

   // monitor: a value inside the range counts as the expected one
   initial
      forever
      begin
         @(look);
         while (notes.size() > 0)
         begin
            n = notes.pop_front();
            v = probe(n.sel);
            check(n.nm, (v >= n.lo && v <= n.hi) ? n.lo : v, n.lo);
         end
      end

   ////////////////////////////////////////////////////////////////////////
   // stimulus, changed on falling edges or a few ns after them, never near a rising edge
   initial
   begin
      void'($urandom(32'h4a5b));
      rst = 1'b1;
      {adaptive_current_enable, learning_launch_wr, slow} = 3'h0;
      {learn_level_increment, learn_dwell_select} = 4'h0;
      {zero_cross_sample_time, prop_gain_divider, integ_gain_divider} = 8'h00;
      learn_base_level = 5'h18;
      full_scale_level = 9'h0f0;
      load_high_thresh = 12'h064;
      load_low_thresh = 12'h028;
      load = 10'h000;
      tick_gap = 5'h0a;
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      for (int c = 0; c < 4; c++)
      begin
         zero_cross_sample_time = c[1:0];
         prop_gain_divider = (c == 3) ? 3'h3 : 3'($urandom_range(7));
         integ_gain_divider = (c == 2) ? 3'h3 : 3'($urandom_range(7));
         @(negedge core_clk);
         note("zc", 7, 40 + 20 * c, 40 + 20 * c);
         note("pdiv", 8, 5 + prop_gain_divider, 5 + prop_gain_divider);
         note("idiv", 9, 5 + integ_gain_divider, 5 + integ_gain_divider);
      end
      note("coil_off", 0, 240, 240);
      adaptive_current_enable = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         learn_level_increment = i[1:0];
         learn_dwell_select = 2'(3 - i);
         tick_gap = 5'(10 + $urandom_range(15));
         load = 10'h000;
         @(posedge half_cycle_tick);
         @(negedge core_clk);
         ticks = 0;
         learning_launch_wr = 1'b1;
         @(negedge core_clk);
         learning_launch_wr = 1'b0;
         note("launch", 1, 1, 1);
         note("complete", 2, 0, 0);
         for (int k = 0; k < 3000 && learning_complete !== 1'b1; k++)
            @(negedge core_clk);
         lvl2 = 192 + ((i == 0) ? 128 : 8 << i);
         note("complete", 2, 1, 1);
         note("launch", 1, 0, 0);
         note("dwell", 10, 32 - 8 * i, 32 - 8 * i);
         note("loss_low", 3, 368, 385);
         note("loss_high", 4, 2 * lvl2 - 16, 2 * lvl2 + 1);
      end
      // light load lowers current; slow sampling meanwhile
      slow = 1'b1;
      for (int k = 0; k < 2000 && load_power_count > 12'h010; k++)
         @(negedge core_clk);
      for (int k = 0; k < 2000 && coil_current_level !== 9'h0c0; k++)
         @(negedge core_clk);
      note("coil_low", 0, 192, 192);
      note("interp", 5, 368, 386);
      note("count", 6, 0, 24);
      load = 10'h0c8;
      for (int k = 0; k < 2000 && load_power_count < 12'h0aa; k++)
         @(negedge core_clk);
      note("coil_full", 0, 240, 240);
      note("interp", 5, 450, 494);
      note("count", 6, 170, 232);
      // disabled: launch refused, results kept, full current
      adaptive_current_enable = 1'b0;
      load = 10'h000;
      learning_launch_wr = 1'b1;
      @(negedge core_clk);
      learning_launch_wr = 1'b0;
      @(negedge core_clk);
      note("launch_off", 1, 0, 0);
      repeat (100) @(negedge core_clk);
      note("coil_off", 0, 240, 240);
      note("low_kept", 3, 368, 385);
      note("high_kept", 4, 496, 513);
      finish_test();
   end
endmodule : tb
